// ---- include/pmt_regs.vh ----
`ifndef PMT_REGS_VH
`define PMT_REGS_VH

// ==========================================================
// Register map (byte addresses)
`define PMT_INST_STRIDE   8'h10
`define PMT_OFF_CONTROL   4'h0
`define PMT_OFF_PERIOD    4'h4
`define PMT_OFF_COUNT     4'h8
`define PMT_OFF_IRQ_FLAG  8'h30
`define PMT_OFF_IRQ_EN    8'h34
`define PMT_NUM_INST      3

// ==========================================================
// Control field positions
`define PMT_PRE_LSB       0
`define PMT_PRE_MSB       1
`define PMT_RUN_BIT       2
`define PMT_POST_LSB      3
`define PMT_POST_MSB      6
`define PMT_CTRL_MASK     8'h7f

// ==========================================================
// Reset values
`define PMT_RST_CONTROL   8'h00
`define PMT_RST_PERIOD    8'hff
`define PMT_RST_COUNT     8'h00

// ==========================================================
// Prescaler terminal counts (ratio minus one)
`define PMT_PRE_DIV1      6'h00
`define PMT_PRE_DIV4      6'h03
`define PMT_PRE_DIV16     6'h0f
`define PMT_PRE_DIV64     6'h3f

// ==========================================================
// AXI responses
`define PMT_RESP_OKAY     2'b00
`define PMT_RESP_SLVERR   2'b10

`endif

// ---- src/pmt_top.v ----
// Function
// - Three identical independent timers, each with own registers, flag, enable.
// - Timers count only the instruction clock, after prescaling.
// - Eight-bit count starts at zero, increments per prescaled tick when enabled.
// - Control bits 1:0 pick prescale 1, 4, 16 or 64.
// - Count compared with period each cycle; match pulses, count clears next.
// - Match feeds postscaler; control bits 6:3 code N gives 1:(N+1).
// - Postscaler completion latches flag; enable gates it onto interrupt.
// - Count and period registers readable and writable at any time.
// - Reset clears count and sets period to all ones.
// - Count write, control write and reset clear prescaler and postscaler.
// - Control write leaves the count value untouched.
// - Unscaled match pulse of each timer goes out as PWM time base.
// - Only first timer offers its output as serial port shift clock.
// - During sleep all timer activity stops, count and period held.
// - Control bit 2 turns the timer on or off.
// - Control bit 7 reads zero and ignores writes.
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`include "pmt_regs.vh"

module pmt_top
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        sleep,
  output reg  [2:0]  match_pulse,
  output reg         spi_shift_clk,
  output reg         irq
);

  // ==========================================================
  // Address decode
  // Returns {valid, instance(2), register(2)}; instance 3 is irq space
  function [4:0] pmt_decode;
    input [7:0] addr;
    begin
      if (addr == `PMT_OFF_IRQ_FLAG)
        pmt_decode = {1'b1, 2'd3, 2'd0};
      else if (addr == `PMT_OFF_IRQ_EN)
        pmt_decode = {1'b1, 2'd3, 2'd1};
      else if (addr[7:4] < `PMT_NUM_INST && addr[3:0] == `PMT_OFF_CONTROL)
        pmt_decode = {1'b1, addr[5:4], 2'd0};
      else if (addr[7:4] < `PMT_NUM_INST && addr[3:0] == `PMT_OFF_PERIOD)
        pmt_decode = {1'b1, addr[5:4], 2'd1};
      else if (addr[7:4] < `PMT_NUM_INST && addr[3:0] == `PMT_OFF_COUNT)
        pmt_decode = {1'b1, addr[5:4], 2'd2};
      else
        pmt_decode = 5'h00;
    end
  endfunction

  function [5:0] pmt_pre_term;
    input [1:0] sel;
    begin
      case (sel)
        2'd0:    pmt_pre_term = `PMT_PRE_DIV1;
        2'd1:    pmt_pre_term = `PMT_PRE_DIV4;
        2'd2:    pmt_pre_term = `PMT_PRE_DIV16;
        default: pmt_pre_term = `PMT_PRE_DIV64;
      endcase
    end
  endfunction

  // ==========================================================
  // Per-instance state
  reg  [7:0] timer_control [0:2];
  reg  [7:0] period_value  [0:2];
  reg  [7:0] count_value   [0:2];
  reg  [5:0] pre_cnt       [0:2];
  reg  [3:0] post_cnt      [0:2];
  reg  [2:0] match_irq_flag;
  reg  [2:0] match_irq_enable;

  wire [4:0] wdec = pmt_decode(s_axi_awaddr);
  wire [4:0] rdec = pmt_decode(s_axi_araddr);
  wire       wr_fire = s_axi_awvalid & s_axi_awready &
                       s_axi_wvalid & s_axi_wready;
  wire       wr_lo   = wr_fire & s_axi_wstrb[0] & wdec[4];
  wire [7:0] wbyte   = s_axi_wdata[7:0];

  // ==========================================================
  // Write channel: take address and data together, answer next
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PMT_RESP_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wdec[4] ? `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
      end
      else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
               !s_axi_awready)
      begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Read channel: one cycle of arready, data the cycle after
  reg [7:0] rbyte;
  integer   r;

  always @*
  begin
    rbyte = 8'h00;
    for (r = 0; r < `PMT_NUM_INST; r = r + 1)
    begin
      // Unmapped reads return zero rather than timer 0's control byte
      if (rdec[4] && rdec[3:2] == r)
      begin
        if (rdec[1:0] == 2'd0)
          rbyte = timer_control[r] & `PMT_CTRL_MASK;
        else if (rdec[1:0] == 2'd1)
          rbyte = period_value[r];
        else if (rdec[1:0] == 2'd2)
          rbyte = count_value[r];
      end
    end
    if (rdec[3:2] == 2'd3)
      rbyte = (rdec[1:0] == 2'd0) ? {5'h00, match_irq_flag} :
                                    {5'h00, match_irq_enable};
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PMT_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, rbyte};
        s_axi_rresp   <= rdec[4] ? `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
      end
      else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
        s_axi_arready <= 1'b1;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Timer strobes, worked out before each edge of aclk
  reg  [2:0] wr_ctrl;
  reg  [2:0] wr_per;
  reg  [2:0] wr_cnt;
  reg  [2:0] run;
  reg  [2:0] tick;
  reg  [2:0] hit;
  reg  [2:0] post_done;
  reg  [2:0] flag_set;
  reg  [2:0] flag_clr;
  integer    j;
  integer    i_reg;
  integer    i_scl;
  integer    i_cnt;

  always @*
  begin
    wr_ctrl   = 3'b000;
    wr_per    = 3'b000;
    wr_cnt    = 3'b000;
    run       = 3'b000;
    tick      = 3'b000;
    hit       = 3'b000;
    post_done = 3'b000;
    flag_clr  = 3'b000;
    for (j = 0; j < `PMT_NUM_INST; j = j + 1)
    begin
      wr_ctrl[j] = wr_lo && wdec[3:2] == j && wdec[1:0] == 2'd0;
      wr_per[j]  = wr_lo && wdec[3:2] == j && wdec[1:0] == 2'd1;
      wr_cnt[j]  = wr_lo && wdec[3:2] == j && wdec[1:0] == 2'd2;
      // Sleep freezes the timer; bus writes still land
      run[j] = timer_control[j][`PMT_RUN_BIT] && !sleep;
      tick[j] = run[j] && pre_cnt[j] ==
                pmt_pre_term(timer_control[j][`PMT_PRE_MSB:`PMT_PRE_LSB]);
      hit[j] = tick[j] && count_value[j] == period_value[j];
      post_done[j] = hit[j] && post_cnt[j] ==
                     timer_control[j][`PMT_POST_MSB:`PMT_POST_LSB];
    end
    // A control write restarts the postscaler, so it beats a completion
    flag_set = post_done & ~wr_ctrl;
    if (wr_lo && wdec[3:0] == 4'hc)
      flag_clr = wbyte[2:0];
  end

  // ==========================================================
  // Software registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (i_reg = 0; i_reg < `PMT_NUM_INST; i_reg = i_reg + 1)
      begin
        timer_control[i_reg] <= `PMT_RST_CONTROL;
        period_value[i_reg]  <= `PMT_RST_PERIOD;
      end
      match_irq_enable <= 3'b000;
    end
    else
    begin
      for (i_reg = 0; i_reg < `PMT_NUM_INST; i_reg = i_reg + 1)
      begin
        if (wr_ctrl[i_reg])
          timer_control[i_reg] <= wbyte & `PMT_CTRL_MASK;
        if (wr_per[i_reg])
          period_value[i_reg] <= wbyte;
      end
      if (wr_lo && wdec[3:0] == 4'hd)
        match_irq_enable <= wbyte[2:0];
    end
  end

  // ==========================================================
  // Prescaler and postscaler, on the instruction clock alone
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (i_scl = 0; i_scl < `PMT_NUM_INST; i_scl = i_scl + 1)
      begin
        pre_cnt[i_scl]  <= 6'h00;
        post_cnt[i_scl] <= 4'h0;
      end
    end
    else
    begin
      for (i_scl = 0; i_scl < `PMT_NUM_INST; i_scl = i_scl + 1)
      begin
        if (wr_ctrl[i_scl] || wr_cnt[i_scl])
        begin
          // Count is left alone by a control write; only scalers restart
          pre_cnt[i_scl]  <= 6'h00;
          post_cnt[i_scl] <= 4'h0;
        end
        else if (run[i_scl])
        begin
          pre_cnt[i_scl] <= tick[i_scl] ? 6'h00 :
                            pre_cnt[i_scl] + 6'h01;
          if (hit[i_scl])
            post_cnt[i_scl] <= post_done[i_scl] ? 4'h0 :
                               post_cnt[i_scl] + 4'h1;
        end
      end
    end
  end

  // ==========================================================
  // Count registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (i_cnt = 0; i_cnt < `PMT_NUM_INST; i_cnt = i_cnt + 1)
        count_value[i_cnt] <= `PMT_RST_COUNT;
    end
    else
    begin
      for (i_cnt = 0; i_cnt < `PMT_NUM_INST; i_cnt = i_cnt + 1)
      begin
        // A software write wins over a same-cycle tick
        if (wr_cnt[i_cnt])
          count_value[i_cnt] <= wbyte;
        else if (tick[i_cnt])
          count_value[i_cnt] <= hit[i_cnt] ? `PMT_RST_COUNT :
                                count_value[i_cnt] + 8'h01;
      end
    end
  end

  // ==========================================================
  // Match pulses and latched flags
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      match_pulse    <= 3'b000;
      match_irq_flag <= 3'b000;
    end
    else
    begin
      // No pulse when a control write restarts the scalers
      match_pulse    <= hit & ~wr_ctrl;
      // A new completion beats a same-cycle software clear
      match_irq_flag <= (match_irq_flag & ~flag_clr) | flag_set;
    end
  end

  // ==========================================================
  // Interrupt and serial clock outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq           <= 1'b0;
      spi_shift_clk <= 1'b0;
    end
    else
    begin
      // One cycle behind the flag so the output stays registered
      irq <= |(match_irq_flag & match_irq_enable);
      // Only instance 0 drives the serial port clock source
      if (match_pulse[0])
        spi_shift_clk <= ~spi_shift_clk;
    end
  end

endmodule

// ---- testbench/pmt_far_end.sv ----
module pmt_far_end
(
  input logic       aclk,
  input logic [2:0] match_pulse,
  input logic       spi_shift_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  int   n_base = 0;
  int   n_shift = 0;
  logic last_clk = 1'b0;
  // ====
  // Time base user and shift clock user, both only listen
  always @(posedge aclk)
  begin
    if (match_pulse[0] === 1'b1) n_base <= n_base + 1;
    if ((spi_shift_clk ^ last_clk) === 1'b1) n_shift <= n_shift + 1;
    last_clk <= spi_shift_clk;
  end
endmodule

// ---- testbench/pmt_monitor.sv ----
module pmt_monitor
(
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_wvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic        sleep,
  input logic [2:0]  match_pulse,
  input logic        spi_shift_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_aw_w_pair: assert property (s_axi_awready |-> s_axi_wready &&
    $past(s_axi_awvalid && s_axi_wvalid)) else $error("bad write take");
  a_b_timing: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("late write answer");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write answer dropped");
  a_r_timing: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("late read answer");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_match_single: assert property (match_pulse != 3'h0 |=>
    (match_pulse & $past(match_pulse)) == 3'h0) else $error("long match");
  a_sleep_freeze: assert property (sleep [*3] |->
    match_pulse == 3'h0) else $error("match during sleep");
  a_spi_follow: assert property ($changed(spi_shift_clk) |->
    match_pulse[0] || $past(match_pulse[0])) else $error("stray shift edge");
endmodule

bind pmt_top pmt_monitor u_mon (.*);

// ---- testbench/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, sleep, irq, spi_shift_clk;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, b;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_val, held;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [2:0]  match_pulse;
  int          fails = 0;
  int          n_tests = 0;
  int          k, c, i;

  pmt_top dut (.*);
  pmt_far_end far (.*);

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // ====
  // Tasks
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // A spent wait bound ends the run
  task automatic tmo(input int n);
    if (n >= 1000)
    begin
      chk("wait bound", 32'h0, 32'h1);
      end_sim;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 1000; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 1000; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd_val = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask
  task automatic rc(input string s, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(s, e, rd_val);
  endtask
  // Irq follows its flag one cycle late, so let it land
  task automatic ci(input string s, input logic [31:0] e);
    repeat (2) @(negedge aclk);
    chk(s, e, {31'h0, irq});
  endtask
  task automatic gap(input int t, output int g);
    int n;
    g = 0;
    for (n = 0; n < 1000; n++)
    begin
      @(negedge aclk);
      if (match_pulse[t] === 1'b1 && g > 0) break;
      if (match_pulse[t] === 1'b1 || g > 0) g++;
    end
    tmo(n);
  endtask
  // ====
  // Tests
  initial
  begin
    aresetn = 1'b0;
    sleep = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc("control", 8'h00, 32'h00);
    rc("period", 8'h04, 32'hff);
    rc("count", 8'h08, 32'h00);
    wr(8'h00, 8'hff);
    rc("control", 8'h00, 32'h7f);
    wr(8'h00, 8'h00);
    chk("mapped wr resp", 32'h0, {30'h0, wr_resp});
    wr(8'h3c, 8'h00);
    chk("unmapped wr resp", 32'h2, {30'h0, wr_resp});
    rd(8'h3c);
    chk("unmapped resp", 32'h2, {30'h0, rd_resp});
    $display("test registers done");
    for (i = 0; i < 4; i++)
    begin
      b = 8'((i % 3) * 16);
      wr(b + 8'h04, 8'h03);
      rc("period", b + 8'h04, 32'h03);
      wr(b + 8'h08, 8'h00);
      wr(b, 8'(4 + i));
      gap(i % 3, c);
      chk("match gap", 32'(4 << (2 * i)), c);
      wr(b, 8'h00);
    end
    $display("test prescale done");
    wr(8'h30, 8'h07);
    wr(8'h34, 8'h02);
    wr(8'h18, 8'h00);
    wr(8'h10, 8'h7c);
    c = 0;
    for (k = 0; k < 1000 && irq !== 1'b1; k++)
    begin
      @(negedge aclk);
      if (match_pulse[1] === 1'b1) c++;
    end
    tmo(k);
    chk("matches per flag", 32'd16, c);
    wr(8'h10, 8'h00);
    rc("flags", 8'h30, 32'h2);
    wr(8'h34, 8'h00);
    ci("irq masked", 32'h0);
    wr(8'h34, 8'h02);
    ci("irq enabled", 32'h1);
    wr(8'h30, 8'h02);
    ci("irq cleared", 32'h0);
    $display("test postscale done");
    wr(8'h28, 8'h80);
    wr(8'h20, 8'h03);
    rc("count kept", 8'h28, 32'h80);
    wr(8'h04, 8'hff);
    wr(8'h00, 8'h04);
    sleep <= 1'b1;
    rd(8'h08);
    held = rd_val;
    repeat (20) @(posedge aclk);
    rc("count asleep", 8'h08, held);
    sleep <= 1'b0;
    wr(8'h00, 8'h00);
    chk("shift edges", far.n_base, far.n_shift);
    $display("test hold and sleep done");
    end_sim;
  end
endmodule
